// ==== design/dbr_pkg.sv ====
// constants, field layouts and carrier types for the loop and brown-out register group
// Notes on behaviour
// [R1] fine step limit bounds closed-loop fine adjustment
// [R2] coarse step limit bounds closed-loop coarse adjustment
// [R3] spread generator takes step and amplitude fields
// [R4] random-interval bit picks constant or pseudo-random pacing
// [R5] closed loop reports 16-bit ratio error
// [R6] measure window is two to exponent cycles
// [R7] snapshot write refreshes values, then ready flag
// [R8] protected writes need unlock write just before
// [R9] brown-out final bit locks, cleared by non-brown-out reset
// [R10] fuse-done bit set on load, skips reload
// [R11] brown-out control: off, reset+irq, irq, reserved
// [R12] level drives threshold, hysteresis bit adds hysteresis
// [R13] software disables detector before changing level
// [R14] regulator final bit locks, cleared by power-on only
// [R15] regulator pulldown bit grounds regulator output
// [R16] config mode bit one means closed loop
// [R17] write-only and reserved bits read zero
package dbr_pkg;
	localparam logic [7:0] OFS_STEP = 8'h00;
	localparam logic [7:0] OFS_SSG = 8'h04;
	localparam logic [7:0] OFS_RATIO = 8'h08;
	localparam logic [7:0] OFS_SYNC = 8'h0C;
	localparam logic [7:0] OFS_BOD = 8'h10;
	localparam logic [7:0] OFS_VREG = 8'h14;
	localparam logic [7:0] OFS_UNLOCK = 8'h18;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h1C;
	localparam logic [7:0] OFS_IRQ_CLR = 8'h20;
	localparam logic [7:0] OFS_IRQ_EN = 8'h24;
	localparam logic [7:0] UNLOCK_KEY = 8'hAA;
	localparam int UNLOCK_KEY_POS = 24;
	localparam int FINE_STEP_LIMIT_POS = 16;
	localparam int COARSE_STEP_LIMIT_POS = 0;
	localparam int SSG_STEP_POS = 16;
	localparam int SSG_AMP_POS = 8;
	localparam int SSG_RAND_POS = 1;
	localparam int SSG_EN_POS = 0;
	localparam int RATIO_ERR_POS = 16;
	localparam int RATIO_EXP_POS = 0;
	localparam int SYNC_POS = 0;
	localparam int BOD_SFV_POS = 31;
	localparam int BOD_FCD_POS = 16;
	localparam int BOD_CTRL_POS = 8;
	localparam int BOD_HYSTERESIS_ON_POS = 6;
	localparam int BOD_LEVEL_POS = 0;
	localparam int VREG_SFV_POS = 31;
	localparam int VREG_PD_POS = 30;
	localparam int IRQ_BOD_POS = 0;
	localparam int IRQ_RDY_POS = 1;
	localparam int IRQ_W = 2;
	localparam logic [1:0] BOD_OFF = 2'h0;
	localparam logic [1:0] BOD_RST_IRQ = 2'h1;
	localparam logic [1:0] BOD_IRQ_ONLY = 2'h2;
	localparam logic [7:0] SSG_CONST_INTERVAL = 8'h40;
	localparam logic [7:0] LFSR_SEED = 8'h5A;
	localparam logic [31:0] RESET_WORD = 32'h0000_0000;
	typedef struct packed {
		logic enable;
		logic random_interval_sel;
		logic [4:0] spread_step;
		logic [4:0] amplitude;
	} dbr_spread_t;
	typedef struct packed {
		logic detector_on;
		logic reset_en;
		logic irq_en;
		logic hysteresis_on;
		logic [5:0] level;
	} dbr_bod_t;
	typedef enum logic [1:0] {
		SNAP_IDLE = 2'b01,
		SNAP_WAIT = 2'b10
	} dbr_snap_state_t;
endpackage

// ==== design/dbr_regs.sv ====
// apb register group for loop step limits, spread generator, ratio, brown-out and regulator
`timescale 1ns/1ps
module dbr_regs
	import dbr_pkg::*;
#(
	parameter int LEVEL_W = 6
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic soft_reset,
	input wire logic soft_reset_from_bod,
	input wire logic flash_cal_busy,
	input wire logic fuse_load,
	input wire logic [1:0] fuse_bod_ctrl,
	input wire logic fuse_bod_hysteresis_on,
	input wire logic [LEVEL_W-1:0] fuse_bod_level,
	input wire logic loop_mode_closed,
	input wire logic [15:0] ratio_error_in,
	input wire logic [4:0] ref_cycle_exponent_in,
	input wire logic loop_sync_done,
	input wire logic bod_trip_pin,
	output logic [8:0] fine_step_limit,
	output logic [7:0] coarse_step_limit,
	output logic step_limit_active,
	output dbr_spread_t spread_cfg,
	output logic spread_tick,
	output logic [31:0] ref_window_cycles,
	output logic loop_sync_req,
	output logic loop_ready_flag,
	output dbr_bod_t bod_cfg,
	output logic bod_reset_req,
	output logic regulator_pulldown,
	output logic irq
);
	// apb decode
	logic setup;
	logic fire;
	logic wr_fire;
	logic rd_setup;
	logic hit_step;
	logic hit_ssg;
	logic hit_ratio;
	logic hit_sync;
	logic hit_bod;
	logic hit_vreg;
	logic hit_unlock;
	logic hit_stat;
	logic hit_clr;
	logic hit_en;
	logic mapped;
	logic prot_ok;
	logic pready_q;
	logic [31:0] prdata_q;
	logic pslverr_q;
	logic unlocked_q;
	assign setup = psel & ~penable;
	assign fire = psel & penable & pready_q;
	assign wr_fire = fire & pwrite;
	assign hit_step = (paddr == OFS_STEP);
	assign hit_ssg = (paddr == OFS_SSG);
	assign hit_ratio = (paddr == OFS_RATIO);
	assign hit_sync = (paddr == OFS_SYNC);
	assign hit_bod = (paddr == OFS_BOD);
	assign hit_vreg = (paddr == OFS_VREG);
	assign hit_unlock = (paddr == OFS_UNLOCK);
	assign hit_stat = (paddr == OFS_IRQ_STAT);
	assign hit_clr = (paddr == OFS_IRQ_CLR);
	assign hit_en = (paddr == OFS_IRQ_EN);
	assign mapped = hit_step | hit_ssg | hit_ratio | hit_sync | hit_bod | hit_vreg
		| hit_unlock | hit_stat | hit_clr | hit_en;
	assign rd_setup = setup & ~pwrite;
	// only the very next access after the key write may land
	assign prot_ok = wr_fire & unlocked_q; // [R8]
	logic unlock_hit;
	assign unlock_hit = wr_fire & hit_unlock
		& (pwdata[UNLOCK_KEY_POS +: 8] == UNLOCK_KEY);
	logic step_wr;
	logic ssg_wr;
	logic en_wr;
	logic clr_wr;
	assign step_wr = prot_ok & hit_step; // [R1] [R2]
	assign ssg_wr = prot_ok & hit_ssg; // [R3]
	assign en_wr = wr_fire & hit_en;
	assign clr_wr = wr_fire & hit_clr;

	// loop step limits and spread generator
	logic [31:0] step_q;
	logic [31:0] ssg_q;
	logic [31:0] step_d;
	logic [31:0] ssg_d;
	assign step_d = {7'h00, pwdata[FINE_STEP_LIMIT_POS +: 9], 8'h00, pwdata[COARSE_STEP_LIMIT_POS +: 8]};
	assign ssg_d = {11'h000, pwdata[SSG_STEP_POS +: 5], 3'h0, pwdata[SSG_AMP_POS +: 5],
		6'h00, pwdata[SSG_RAND_POS], pwdata[SSG_EN_POS]}; // [R17]

	// brown-out register
	logic bod_sfv_q;
	logic bod_fcd_q;
	logic [1:0] bod_ctrl_q;
	logic bod_hysteresis_on_q;
	logic [LEVEL_W-1:0] bod_level_q;
	logic bod_wr;
	logic fuse_apply;
	// a locked register ignores the write but the bus still completes
	assign bod_wr = prot_ok & hit_bod & ~bod_sfv_q; // [R9]
	// reload skipped after a brown-out reset since the done bit survives it
	assign fuse_apply = fuse_load & ~bod_fcd_q; // [R10]

	// regulator register, only power-on reset clears it
	logic vreg_sfv_q;
	logic vreg_pd_q;
	logic vreg_wr;
	assign vreg_wr = prot_ok & hit_vreg & ~vreg_sfv_q; // [R14]

	// ratio snapshot
	logic [15:0] ratio_err_q;
	logic [4:0] ratio_exp_q;
	dbr_snap_state_t snap_q;
	dbr_snap_state_t snap_d;
	logic sync_wr;
	logic snap_done;
	assign sync_wr = prot_ok & hit_sync & pwdata[SYNC_POS]; // [R7]
	assign snap_done = (snap_q == SNAP_WAIT) & loop_sync_done;
	always_comb begin
		case (snap_q)
			SNAP_IDLE: snap_d = sync_wr ? SNAP_WAIT : SNAP_IDLE;
			SNAP_WAIT: snap_d = loop_sync_done ? SNAP_IDLE : SNAP_WAIT;
			default: snap_d = SNAP_IDLE;
		endcase
	end

	// brown-out trip pin synchroniser
	logic trip_s1_q;
	logic trip_s2_q;
	logic trip_prev_q;
	logic trip_rise;
	logic bod_active;
	assign trip_rise = trip_s2_q & ~trip_prev_q;
	assign bod_active = (bod_ctrl_q == BOD_RST_IRQ) | (bod_ctrl_q == BOD_IRQ_ONLY); // [R11]

	// interrupts
	logic [IRQ_W-1:0] irq_stat_q;
	logic [IRQ_W-1:0] irq_en_q;
	logic [IRQ_W-1:0] irq_set;
	logic [IRQ_W-1:0] irq_clr;
	logic [IRQ_W-1:0] irq_stat_d;
	assign irq_set[IRQ_BOD_POS] = trip_rise & bod_active;
	assign irq_set[IRQ_RDY_POS] = snap_done;
	assign irq_clr = clr_wr ? pwdata[IRQ_W-1:0] : '0;
	// a new event in the clearing cycle stays visible
	assign irq_stat_d = (irq_stat_q & ~irq_clr) | irq_set;

	// spread interval pacing
	logic [7:0] lfsr_q;
	logic [7:0] ssg_cnt_q;
	logic [7:0] ssg_reload;
	logic ssg_hit;
	assign ssg_reload = ssg_q[SSG_RAND_POS] ? (lfsr_q | 8'h01) : SSG_CONST_INTERVAL; // [R4]
	assign ssg_hit = ssg_q[SSG_EN_POS] & (ssg_cnt_q == 8'h00);

	// read mux
	logic [31:0] bod_word;
	logic [31:0] vreg_word;
	logic [31:0] ratio_word;
	logic [31:0] rd_mux;
	assign bod_word = {bod_sfv_q, 14'h0000, bod_fcd_q, 6'h00, bod_ctrl_q, 1'b0, bod_hysteresis_on_q,
		LEVEL_W'(bod_level_q)};
	assign vreg_word = {vreg_sfv_q, vreg_pd_q, 30'h0000_0000};
	assign ratio_word = {ratio_err_q, 11'h000, ratio_exp_q}; // [R5] [R6]
	assign rd_mux = hit_step ? step_q :
		hit_ssg ? ssg_q :
		hit_ratio ? ratio_word :
		hit_bod ? bod_word :
		hit_vreg ? vreg_word :
		hit_stat ? {30'h0000_0000, irq_stat_q} :
		hit_en ? {30'h0000_0000, irq_en_q} :
		RESET_WORD; // [R17]

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			pready_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
			pslverr_q <= 1'b0;
		end else begin
			pready_q <= setup;
			prdata_q <= rd_setup ? rd_mux : 32'h0000_0000;
			pslverr_q <= setup & ~mapped;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			unlocked_q <= 1'b0;
		end else if (fire) begin
			unlocked_q <= unlock_hit; // [R8]
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			step_q <= 32'h0000_0000;
			ssg_q <= 32'h0000_0000;
		end else if (soft_reset) begin
			step_q <= 32'h0000_0000;
			ssg_q <= 32'h0000_0000;
		end else begin
			if (step_wr) step_q <= step_d; // [R1] [R2]
			if (ssg_wr) ssg_q <= ssg_d; // [R3]
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			bod_sfv_q <= 1'b0;
			bod_fcd_q <= 1'b0;
			bod_ctrl_q <= 2'h0;
			bod_hysteresis_on_q <= 1'b0;
			bod_level_q <= '0;
		end else if (soft_reset & ~soft_reset_from_bod) begin
			bod_sfv_q <= 1'b0; // [R9]
			bod_fcd_q <= 1'b0; // [R10]
		end else if (fuse_apply) begin
			bod_ctrl_q <= fuse_bod_ctrl;
			bod_hysteresis_on_q <= fuse_bod_hysteresis_on;
			bod_level_q <= fuse_bod_level;
			bod_fcd_q <= 1'b1; // [R10]
			bod_sfv_q <= 1'b0;
		end else if (flash_cal_busy) begin
			bod_sfv_q <= 1'b0; // [R9]
		end else if (bod_wr) begin
			bod_sfv_q <= pwdata[BOD_SFV_POS];
			bod_fcd_q <= pwdata[BOD_FCD_POS];
			bod_ctrl_q <= pwdata[BOD_CTRL_POS +: 2];
			bod_hysteresis_on_q <= pwdata[BOD_HYSTERESIS_ON_POS];
			// level changes are taken as given; the detector should be off first
			bod_level_q <= pwdata[BOD_LEVEL_POS +: LEVEL_W]; // [R13]
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			vreg_sfv_q <= 1'b0;
			vreg_pd_q <= 1'b0;
		end else if (vreg_wr) begin
			vreg_sfv_q <= pwdata[VREG_SFV_POS]; // [R14]
			vreg_pd_q <= pwdata[VREG_PD_POS]; // [R15]
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			snap_q <= SNAP_IDLE;
			ratio_err_q <= 16'h0000;
			ratio_exp_q <= 5'h00;
		end else begin
			snap_q <= snap_d;
			if (snap_done) begin
				// ratio error only meaningful in closed loop
				ratio_err_q <= loop_mode_closed ? ratio_error_in : 16'h0000; // [R5] [R16]
				ratio_exp_q <= ref_cycle_exponent_in; // [R6]
			end
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			trip_s1_q <= 1'b0;
			trip_s2_q <= 1'b0;
			trip_prev_q <= 1'b0;
		end else begin
			trip_s1_q <= bod_trip_pin;
			trip_s2_q <= trip_s1_q;
			trip_prev_q <= trip_s2_q;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			irq_stat_q <= '0;
			irq_en_q <= '0;
		end else begin
			irq_stat_q <= irq_stat_d;
			if (en_wr) irq_en_q <= pwdata[IRQ_W-1:0];
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			lfsr_q <= LFSR_SEED;
			ssg_cnt_q <= 8'h00;
		end else begin
			lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
			if (~ssg_q[SSG_EN_POS]) ssg_cnt_q <= 8'h00;
			else if (ssg_hit) ssg_cnt_q <= ssg_reload; // [R4]
			else ssg_cnt_q <= ssg_cnt_q - 8'h01;
		end
	end

	// registered outputs
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			fine_step_limit <= 9'h000;
			coarse_step_limit <= 8'h00;
			step_limit_active <= 1'b0;
			spread_cfg <= '0;
			spread_tick <= 1'b0;
			ref_window_cycles <= 32'h0000_0001;
			loop_sync_req <= 1'b0;
			loop_ready_flag <= 1'b0;
			bod_cfg <= '0;
			bod_reset_req <= 1'b0;
			regulator_pulldown <= 1'b0;
			irq <= 1'b0;
		end else begin
			fine_step_limit <= step_q[FINE_STEP_LIMIT_POS +: 9]; // [R1]
			coarse_step_limit <= step_q[COARSE_STEP_LIMIT_POS +: 8]; // [R2]
			step_limit_active <= loop_mode_closed; // [R16]
			spread_cfg.enable <= ssg_q[SSG_EN_POS];
			spread_cfg.random_interval_sel <= ssg_q[SSG_RAND_POS];
			spread_cfg.spread_step <= ssg_q[SSG_STEP_POS +: 5]; // [R3]
			spread_cfg.amplitude <= ssg_q[SSG_AMP_POS +: 5]; // [R3]
			spread_tick <= ssg_hit; // [R4]
			ref_window_cycles <= 32'h0000_0001 << ratio_exp_q; // [R6]
			loop_sync_req <= sync_wr; // [R7]
			if (sync_wr) loop_ready_flag <= 1'b0;
			else if (snap_done) loop_ready_flag <= 1'b1; // [R7]
			bod_cfg.detector_on <= bod_active; // [R11]
			bod_cfg.reset_en <= (bod_ctrl_q == BOD_RST_IRQ); // [R11]
			bod_cfg.irq_en <= bod_active & irq_en_q[IRQ_BOD_POS];
			bod_cfg.hysteresis_on <= bod_hysteresis_on_q; // [R12]
			bod_cfg.level <= 6'(bod_level_q); // [R12]
			bod_reset_req <= (bod_ctrl_q == BOD_RST_IRQ) & trip_s2_q; // [R11]
			regulator_pulldown <= vreg_pd_q; // [R15]
			irq <= |(irq_stat_d & irq_en_q);
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
endmodule // dbr_regs

// ==== test/dbr_regs_checker.sv ====
// assertion checker for the loop and brown-out register group
`timescale 1ns/1ps
module dbr_regs_checker
	import dbr_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic soft_reset,
	input wire logic soft_reset_from_bod,
	input wire logic flash_cal_busy,
	input wire logic loop_sync_done,
	input wire logic [8:0] fine_step_limit,
	input wire logic [7:0] coarse_step_limit,
	input wire dbr_spread_t spread_cfg,
	input wire logic loop_sync_req,
	input wire logic loop_ready_flag,
	input wire dbr_bod_t bod_cfg,
	input wire logic regulator_pulldown
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	logic unl_q, bsfv_q, vsfv_q, en_q, pend_q;
	logic [31:0] wd_q;
	wire acc = psel && penable && pready;
	wire wr = acc && pwrite && !soft_reset;
	wire ok = wr && unl_q;
	wire bod_ok = ok && paddr == OFS_BOD && !bsfv_q && pwdata[9:8] != 2'h3;
	// lock bits tracked here, as they never reach the ports
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			unl_q <= 1'b0;
			bsfv_q <= 1'b0;
			vsfv_q <= 1'b0;
			en_q <= 1'b0;
			pend_q <= 1'b0;
			wd_q <= 32'h0;
		end else begin
			// data of the last completed access; outputs follow two edges later
			if (acc) begin
				wd_q <= pwdata;
				unl_q <= pwrite && paddr == OFS_UNLOCK && pwdata[31:24] == UNLOCK_KEY;
			end
			if (acc && pwrite && paddr == OFS_IRQ_EN)
				en_q <= pwdata[IRQ_BOD_POS];
			if (loop_sync_done)
				pend_q <= 1'b0;
			else if (ok && paddr == OFS_SYNC && pwdata[0])
				pend_q <= 1'b1;
			if (flash_cal_busy || (soft_reset && !soft_reset_from_bod))
				bsfv_q <= 1'b0;
			else if (bod_ok && pwdata[31])
				bsfv_q <= 1'b1;
			if (ok && paddr == OFS_VREG && pwdata[31])
				vsfv_q <= 1'b1;
		end
	end
	chk_step_locked: assert property (
		wr && !unl_q && paddr == OFS_STEP |-> ##2 $stable({fine_step_limit, coarse_step_limit}))
		else $error("locked step write took effect");
	chk_step_load: assert property (
		ok && paddr == OFS_STEP |-> ##2 fine_step_limit == wd_q[24:16]
		&& coarse_step_limit == wd_q[7:0]) else $error("step limits not loaded");
	chk_spread_load: assert property (
		ok && paddr == OFS_SSG |-> ##2 spread_cfg == {wd_q[0], wd_q[1], wd_q[20:16], wd_q[12:8]})
		else $error("spread fields not loaded");
	chk_sync_pulse: assert property (
		ok && paddr == OFS_SYNC && pwdata[0] |=> loop_sync_req && !loop_ready_flag
		##1 !loop_sync_req) else $error("snapshot request pulse wrong");
	chk_ready_set: assert property (
		loop_sync_done && pend_q && !ok |=> loop_ready_flag) else $error("ready flag not set");
	chk_bod_load: assert property (
		bod_ok |-> ##2 bod_cfg == {wd_q[9:8] != 2'h0, wd_q[9:8] == 2'h1,
		wd_q[9:8] != 2'h0 && en_q, wd_q[6], wd_q[5:0]}) else $error("detector decode wrong");
	chk_bod_final: assert property (
		wr && paddr == OFS_BOD && (bsfv_q || !unl_q) |-> ##2 $stable(bod_cfg))
		else $error("locked detector register changed");
	chk_vreg_final: assert property (
		wr && paddr == OFS_VREG && (vsfv_q || !unl_q) |-> ##2 $stable(regulator_pulldown))
		else $error("locked regulator register changed");
	chk_vreg_pulldown: assert property (
		ok && paddr == OFS_VREG && !vsfv_q |-> ##2 regulator_pulldown == wd_q[30])
		else $error("pulldown not loaded");
	chk_sync_reads_zero: assert property (
		acc && !pwrite && paddr == OFS_SYNC |-> prdata == 32'h0)
		else $error("write-only register read nonzero");
endmodule // dbr_regs_checker
bind dbr_regs dbr_regs_checker dbr_regs_checker_i (.clock, .rst, .psel, .penable, .pwrite,
	.paddr, .pwdata, .prdata, .pready, .soft_reset, .soft_reset_from_bod, .flash_cal_busy,
	.loop_sync_done, .fine_step_limit, .coarse_step_limit, .spread_cfg, .loop_sync_req,
	.loop_ready_flag, .bod_cfg, .regulator_pulldown);

// ==== test/dbr_regs_tb.sv ====
// self-checking bench for the loop and brown-out register group
`timescale 1ns/1ps
module dbr_regs_tb;
	import dbr_pkg::*;
	logic clock = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
	logic soft_reset = 0, soft_reset_from_bod = 0, flash_cal_busy = 0, fuse_load = 0;
	logic fuse_bod_hysteresis_on = 0, loop_mode_closed = 0, loop_sync_done = 0, bod_trip_pin = 0;
	logic step_limit_active, spread_tick, loop_sync_req, loop_ready_flag, bod_reset_req;
	logic regulator_pulldown, irq;
	logic [1:0] fuse_bod_ctrl = 0;
	logic [5:0] fuse_bod_level = 0;
	logic [7:0] paddr = 0, coarse_step_limit;
	logic [8:0] fine_step_limit;
	logic [15:0] ratio_error_in = 0;
	logic [4:0] ref_cycle_exponent_in = 0;
	logic [31:0] pwdata = 0, prdata, ref_window_cycles, v, e;
	dbr_spread_t spread_cfg;
	dbr_bod_t bod_cfg;
	logic [32:0] q[$];
	int fails = 0, checked = 0, cyc = 0, g, d;
	always #20 clock = ~clock;
	dbr_regs dbr_regs_i (.clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .soft_reset, .soft_reset_from_bod, .flash_cal_busy, .fuse_load,
		.fuse_bod_ctrl, .fuse_bod_hysteresis_on, .fuse_bod_level, .loop_mode_closed, .ratio_error_in,
		.ref_cycle_exponent_in, .loop_sync_done, .bod_trip_pin, .fine_step_limit,
		.coarse_step_limit, .step_limit_active, .spread_cfg, .spread_tick, .ref_window_cycles,
		.loop_sync_req, .loop_ready_flag, .bod_cfg, .bod_reset_req, .regulator_pulldown, .irq);
	task automatic chk(input logic [32:0] got, input logic [32:0] exp);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: seen %h wanted %h", $time, got, exp);
		end
	endtask
	task automatic give_verdict;
		$display("compares %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// ends at the falling edge after the access; registered outputs of a written register update one edge later
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dt);
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= dt;
		@(posedge clock) penable <= 1'b1;
		@(negedge clock);
		while (pready !== 1'b1)
			@(negedge clock);
		@(posedge clock);
		psel <= 1'b0;
		penable <= 1'b0;
		@(negedge clock);
	endtask
	task automatic uw(input logic [7:0] a, input logic [31:0] dt);
		apb(1'b1, OFS_UNLOCK, {UNLOCK_KEY, 24'h0});
		apb(1'b1, a, dt);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		q.push_back({1'b0, x});
		apb(1'b0, a, 32'h0);
	endtask
	task automatic sreset(input logic b);
		@(posedge clock);
		soft_reset <= 1'b1;
		soft_reset_from_bod <= b;
		@(posedge clock) soft_reset <= 1'b0;
	endtask
	task automatic gap(output int n);
		do @(negedge clock); while (spread_tick !== 1'b1);
		n = 0;
		do begin @(negedge clock); n++; end while (spread_tick !== 1'b1);
	endtask
	// read results are compared in bus order as they appear
	always @(posedge clock)
		if (psel && penable && pready === 1'b1 && !pwrite)
			chk({pslverr, prdata}, q.pop_front());
	always @(posedge clock) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			give_verdict;
		end
	end
	initial begin
		void'($urandom(32'h4BB4B151));
		repeat (5) @(posedge clock);
		rst <= 1'b0;
		for (int i = 0; i < 10; i++)
			rd(8'(4 * i), 32'h0);
		q.push_back({1'b1, 32'h0});
		apb(1'b0, 8'h28, 32'h0);
		$display("reset values done");
		e = 32'h0;
		for (int i = 0; i < 4; i++) begin
			v = $urandom;
			apb(1'b1, OFS_STEP, v);
			rd(OFS_STEP, e);
			uw(OFS_STEP, v);
			e = v & 32'h01FF00FF;
			rd(OFS_STEP, e);
			chk({fine_step_limit, coarse_step_limit}, {e[24:16], e[7:0]});
		end
		apb(1'b1, OFS_UNLOCK, {UNLOCK_KEY, 24'h0});
		rd(OFS_RATIO, 32'h0);
		apb(1'b1, OFS_STEP, 32'h0);
		rd(OFS_STEP, e);
		$display("step limits done");
		v = ($urandom & 32'h001F1F00) | 32'h1;
		uw(OFS_SSG, v);
		rd(OFS_SSG, v);
		chk(spread_cfg, {v[0], v[1], v[20:16], v[12:8]});
		gap(g);
		chk(g, SSG_CONST_INTERVAL + 1);
		uw(OFS_SSG, v | 32'h2);
		d = 0;
		for (int i = 0; i < 4; i++) begin
			gap(g);
			d += (g != SSG_CONST_INTERVAL + 1);
		end
		chk(d != 0, 1'b1);
		$display("spread done");
		for (int m = 0; m < 2; m++) begin
			@(posedge clock);
			loop_mode_closed <= m[0];
			ratio_error_in <= 16'($urandom);
			ref_cycle_exponent_in <= 5'($urandom);
			uw(OFS_SYNC, 32'h1);
			chk({loop_sync_req, loop_ready_flag}, 2'b10);
			@(posedge clock) loop_sync_done <= 1'b1;
			@(posedge clock) loop_sync_done <= 1'b0;
			@(negedge clock);
			chk(loop_ready_flag, 1'b1);
			chk(step_limit_active, m[0]);
			rd(OFS_RATIO, {m[0] ? ratio_error_in : 16'h0, 11'h0, ref_cycle_exponent_in});
			chk(ref_window_cycles, 32'h1 << ref_cycle_exponent_in);
			rd(OFS_SYNC, 32'h0);
		end
		rd(OFS_IRQ_STAT, 32'h2);
		chk(irq, 1'b0);
		apb(1'b1, OFS_IRQ_EN, 32'h3);
		@(negedge clock);
		chk(irq, 1'b1);
		apb(1'b1, OFS_IRQ_CLR, 32'h2);
		@(negedge clock);
		chk(irq, 1'b0);
		$display("snapshot done");
		@(posedge clock);
		fuse_bod_ctrl <= 2'h2;
		fuse_bod_hysteresis_on <= 1'b1;
		fuse_bod_level <= 6'($urandom);
		fuse_load <= 1'b1;
		@(posedge clock) fuse_load <= 1'b0;
		e = {15'h0, 1'b1, 6'h0, 2'h2, 1'b0, 1'b1, fuse_bod_level};
		rd(OFS_BOD, e);
		@(posedge clock);
		fuse_bod_ctrl <= 2'h1;
		fuse_load <= 1'b1;
		@(posedge clock) fuse_load <= 1'b0;
		rd(OFS_BOD, e);
		// level changes only while the detector is off
		uw(OFS_BOD, {26'h0, fuse_bod_level});
		v = {26'h0, 6'($urandom)};
		for (int c = 0; c < 3; c++) begin
			uw(OFS_BOD, v | (c << 8) | (c << 6));
			@(negedge clock);
			chk(bod_cfg, {c != 0, c == 1, c != 0, c[0], v[5:0]});
		end
		uw(OFS_BOD, v | 32'h100);
		@(posedge clock) bod_trip_pin <= 1'b1;
		repeat (4) @(negedge clock);
		chk(bod_reset_req, 1'b1);
		rd(OFS_IRQ_STAT, 32'h1);
		chk(irq, 1'b1);
		@(posedge clock) bod_trip_pin <= 1'b0;
		uw(OFS_BOD, v | 32'h80000200);
		uw(OFS_BOD, v);
		sreset(1'b1);
		uw(OFS_BOD, v);
		chk(bod_cfg.detector_on, 1'b1);
		@(posedge clock) flash_cal_busy <= 1'b1;
		@(posedge clock) flash_cal_busy <= 1'b0;
		uw(OFS_BOD, v);
		@(negedge clock);
		chk(bod_cfg.detector_on, 1'b0);
		$display("brownout done");
		uw(OFS_VREG, 32'h40000000);
		@(negedge clock);
		chk(regulator_pulldown, 1'b1);
		uw(OFS_VREG, 32'h0);
		@(negedge clock);
		chk(regulator_pulldown, 1'b0);
		uw(OFS_VREG, 32'hC0000000);
		sreset(1'b0);
		uw(OFS_VREG, 32'h0);
		chk(regulator_pulldown, 1'b1);
		rd(OFS_VREG, 32'hC0000000);
		$display("regulator done");
		give_verdict;
	end
endmodule // dbr_regs_tb
